// [pkg/ldi_pkg.sv]
// Constants and carrier types of the LED driver serial target port.
// Assumes a single core clock; pin inputs arrive asynchronous to it.
package ldi_pkg;

	// ----------------------------------------
	// Address layout
	// ----------------------------------------
	localparam logic [2:0] LDI_ADDR_FIXED = 3'h4;
	localparam int LDI_DIR_POS = 0;
	localparam logic [1:0] LDI_STRAP_GND = 2'h0;
	localparam logic [1:0] LDI_STRAP_SCL = 2'h1;
	localparam logic [1:0] LDI_STRAP_SDA = 2'h2;
	localparam logic [1:0] LDI_STRAP_VCC = 2'h3;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int LDI_CLK_NS = 100;
	localparam int LDI_SCL_HIGH_MIN_NS = 260;
	// Synchroniser plus edge detect needs this many samples of a high phase
	localparam int LDI_SCL_HIGH_MIN_CYC = (LDI_SCL_HIGH_MIN_NS + LDI_CLK_NS - 1) / LDI_CLK_NS;
	localparam int LDI_SAMPLES_NEEDED = 2;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] LDI_PTR_RST = 8'h00;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} ldi_wr_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic strap_high;
		logic strap_low;
	} ldi_pins_t;

	typedef enum logic [8:0] {
		LDI_IDLE = 9'h001,
		LDI_ADDR = 9'h002,
		LDI_ACK_ADDR = 9'h004,
		LDI_REG = 9'h008,
		LDI_ACK_REG = 9'h010,
		LDI_WDATA = 9'h020,
		LDI_ACK_DATA = 9'h040,
		LDI_RDATA = 9'h080,
		LDI_RACK = 9'h100
	} ldi_state_t;

endpackage

// [logic/ldi_strap_decode.sv]
// Four-level strap decoder for the two address strap pins.
// Assumes synchronised strap, clock and data levels on the core clock.
`timescale 1ns/1ps
module ldi_strap_decode
	import ldi_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Synchronised levels
	input wire logic scl,
	input wire logic sda,
	input wire logic [1:0] strap,
	// Decoded bits, pair 1 above pair 0
	output logic [3:0] addr_bits
);

	// ----------------------------------------
	// Observation flags per pin
	// ----------------------------------------
	logic [1:0] seen_high, seen_low, off_scl;
	logic [1:0] next_seen_high, next_seen_low, next_off_scl;
	// Synchroniser reset values are not pin levels; flags wait two edges
	logic [1:0] armed, next_armed;

	function automatic logic [1:0] ldi_level(input logic hi, input logic lo, input logic off);
		if (!hi)
			ldi_level = LDI_STRAP_GND;
		else if (!lo)
			ldi_level = LDI_STRAP_VCC;
		else if (!off)
			ldi_level = LDI_STRAP_SCL;
		else
			ldi_level = LDI_STRAP_SDA;
	endfunction

	always_comb
	begin
		next_armed = {armed[0], 1'b1};
		for (int i = 0; i < 2; i++)
		begin
			next_seen_high[i] = seen_high[i] | (armed[1] & strap[i]);
			next_seen_low[i] = seen_low[i] | (armed[1] & ~strap[i]);
			// A data-tied strap parts from the clock at the very first start
			next_off_scl[i] = off_scl[i] | (armed[1] & (strap[i] != scl));
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			seen_high <= 2'h0;
			seen_low <= 2'h0;
			off_scl <= 2'h0;
			armed <= 2'h0;
		end
		else
		begin
			armed <= next_armed;
			seen_high <= next_seen_high;
			seen_low <= next_seen_low;
			off_scl <= next_off_scl;
		end
	end

	// Limitation: clock and data straps both look high until the bus moves
	always_comb
	begin
		addr_bits[3:2] = ldi_level(seen_high[1], seen_low[1], off_scl[1]);
		addr_bits[1:0] = ldi_level(seen_high[0], seen_low[0], off_scl[0]);
	end

	// sda is unused beyond keeping the port symmetric for the bench
	logic unused_sda;
	assign unused_sda = sda;

endmodule

// [logic/ldi_target.sv]
// Serial bus target port of the LED driver: address match, register
// pointer, byte writes with auto-increment and repeated-start reads.
// Assumes the register bank sits on clk and answers rd_data in time.
//
// How it works
// - First byte: seven address bits above, direction bit below; zero writes.
// - Own address is 100, then high strap pair, then low strap pair.
// - Strap ground 00, clock line 01, data line 10, supply 11.
// - Data is sampled while the clock is high and held stable then.
// - Data line stays released and high when the bus is idle.
// - Falling data with clock high is a start; compare the next byte.
// - Device pulls data low during the ninth pulse only on address match.
// - After a write address, the register address byte is acknowledged.
// - Each following data byte is received and acknowledged.
// - Rising data with clock high is a stop; return to idle.
// - Pointer increments during each data acknowledge for consecutive registers.
// - Read: write register address, repeated start, then read address returns data.
// - Any register of the map can be returned by a read.
`timescale 1ns/1ps
module ldi_target
	import ldi_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Bus and strap pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic strap_in_low,
	input wire logic strap_in_high,
	// Register bank write side
	output ldi_pkg::ldi_wr_t wr,
	output logic wr_valid,
	// Register bank read side
	output logic rd_req,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data,
	// Status
	output logic busy
);
	import ldi_pkg::*;

	initial
	begin
		if (LDI_SCL_HIGH_MIN_CYC < LDI_SAMPLES_NEEDED)
			$error("Core clock too slow for the serial clock");
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	ldi_pins_t pin_meta, pin_sync, pin_prev;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_meta <= 4'hf;
			pin_sync <= 4'hf;
			pin_prev <= 4'hf;
		end
		else
		begin
			pin_meta <= {scl_in, sda_in, strap_in_high, strap_in_low};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	logic scl_rise, scl_fall, start_seen, stop_seen;
	assign scl_rise = pin_sync.scl & ~pin_prev.scl;
	assign scl_fall = ~pin_sync.scl & pin_prev.scl;
	assign start_seen = pin_sync.scl & pin_prev.scl & pin_prev.sda & ~pin_sync.sda;
	assign stop_seen = pin_sync.scl & pin_prev.scl & ~pin_prev.sda & pin_sync.sda;

	// ----------------------------------------
	// Own address
	// ----------------------------------------
	logic [3:0] strap_bits;
	logic [6:0] own_addr;

	ldi_strap_decode u_strap (
		.clk(clk),
		.rst_n(rst_n),
		.scl(pin_sync.scl),
		.sda(pin_sync.sda),
		.strap({pin_sync.strap_high, pin_sync.strap_low}),
		.addr_bits(strap_bits)
	);

	assign own_addr = {LDI_ADDR_FIXED, strap_bits};

	// ----------------------------------------
	// Transfer state
	// ----------------------------------------
	ldi_state_t st, next_st;
	logic [2:0] bit_cnt, next_bit_cnt;
	logic [7:0] shreg, next_shreg;
	logic [7:0] txbyte, next_txbyte;
	logic [7:0] ptr, next_ptr;
	logic rw, next_rw;
	logic next_sda_oe, next_wr_valid, next_rd_req, next_busy;
	ldi_wr_t next_wr;
	logic [7:0] next_rd_addr;
	logic [7:0] byte_in;

	assign byte_in = {shreg[6:0], pin_sync.sda};

	always_comb
	begin
		next_st = st;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_txbyte = txbyte;
		next_ptr = ptr;
		next_rw = rw;
		next_sda_oe = sda_oe;
		next_wr = wr;
		next_wr_valid = 1'b0;
		next_rd_req = 1'b0;
		next_rd_addr = rd_addr;
		if (start_seen)
		begin
			// Repeated start keeps the pointer for the read that follows
			next_st = LDI_ADDR;
			next_bit_cnt = 3'h0;
			next_sda_oe = 1'b0;
		end
		else if (stop_seen)
		begin
			next_st = LDI_IDLE;
			next_sda_oe = 1'b0;
		end
		else
		begin
			case (st)
				LDI_IDLE:
				begin
					next_sda_oe = 1'b0;
				end
				LDI_ADDR, LDI_REG, LDI_WDATA:
				begin
					if (scl_rise)
					begin
						next_shreg = byte_in;
						next_bit_cnt = bit_cnt + 3'h1;
						if (bit_cnt == 3'h7)
						begin
							if (st == LDI_ADDR)
							begin
								if (byte_in[7:1] == own_addr)
								begin
									next_st = LDI_ACK_ADDR;
									next_rw = byte_in[LDI_DIR_POS];
									next_rd_req = byte_in[LDI_DIR_POS];
									next_rd_addr = ptr;
								end
								else
									next_st = LDI_IDLE;
							end
							else if (st == LDI_REG)
							begin
								next_ptr = byte_in;
								next_st = LDI_ACK_REG;
							end
							else
								next_st = LDI_ACK_DATA;
						end
					end
				end
				LDI_ACK_ADDR, LDI_ACK_REG, LDI_ACK_DATA:
				begin
					if (scl_fall && !sda_oe)
					begin
						next_sda_oe = 1'b1;
						if (st == LDI_ACK_DATA)
						begin
							next_wr = '{addr: ptr, data: shreg};
							next_wr_valid = 1'b1;
							next_ptr = ptr + 8'h01;
						end
					end
					else if (scl_fall)
					begin
						next_bit_cnt = 3'h0;
						if (st == LDI_ACK_ADDR && rw)
						begin
							next_st = LDI_RDATA;
							next_txbyte = rd_data;
							next_sda_oe = ~rd_data[7];
						end
						else
						begin
							next_st = (st == LDI_ACK_ADDR) ? LDI_REG : LDI_WDATA;
							next_sda_oe = 1'b0;
						end
					end
				end
				LDI_RDATA:
				begin
					if (scl_fall)
					begin
						next_bit_cnt = bit_cnt + 3'h1;
						next_txbyte = {txbyte[6:0], 1'b0};
						if (bit_cnt == 3'h7)
						begin
							next_sda_oe = 1'b0;
							next_st = LDI_RACK;
						end
						else
							next_sda_oe = ~txbyte[6];
					end
				end
				LDI_RACK:
				begin
					if (scl_rise)
					begin
						if (!pin_sync.sda)
						begin
							// Next byte is fetched now, driven at the coming fall
							next_ptr = ptr + 8'h01;
							next_rd_addr = ptr + 8'h01;
							next_rd_req = 1'b1;
							next_rw = 1'b1;
						end
						else
						begin
							next_st = LDI_IDLE;
							next_rw = 1'b0;
						end
					end
					else if (scl_fall && rw)
					begin
						next_st = LDI_RDATA;
						next_bit_cnt = 3'h0;
						next_txbyte = rd_data;
						next_sda_oe = ~rd_data[7];
					end
				end
				default:
				begin
					next_st = LDI_IDLE;
					next_sda_oe = 1'b0;
				end
			endcase
		end
		next_busy = (next_st != LDI_IDLE);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= LDI_IDLE;
			bit_cnt <= 3'h0;
			shreg <= 8'h00;
			txbyte <= 8'h00;
			ptr <= LDI_PTR_RST;
			rw <= 1'b0;
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
			wr <= '0;
			wr_valid <= 1'b0;
			rd_req <= 1'b0;
			rd_addr <= LDI_PTR_RST;
			busy <= 1'b0;
		end
		else
		begin
			st <= next_st;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			txbyte <= next_txbyte;
			ptr <= next_ptr;
			rw <= next_rw;
			sda_oe <= next_sda_oe;
			sda_out <= 1'b0;
			wr <= next_wr;
			wr_valid <= next_wr_valid;
			rd_req <= next_rd_req;
			rd_addr <= next_rd_addr;
			busy <= next_busy;
		end
	end

endmodule

// [bench/ldi_target_assertions.sv]
// Pin-level checks of the serial target port.
// Assumes binding to ldi_target; pins seen raw, before synchronisers.
`timescale 1ns/1ps
module ldi_target_chk
	import ldi_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic strap_in_low,
	input wire logic strap_in_high,
	// Bank side
	input wire ldi_pkg::ldi_wr_t wr,
	input wire logic wr_valid,
	input wire logic rd_req,
	input wire logic [7:0] rd_addr,
	input wire logic [7:0] rd_data,
	input wire logic busy
);
	logic scl_d, sda_d, seen, stp, sta;
	logic [7:0] last;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	assign stp = scl_d && scl_in && !sda_d && sda_in;
	assign sta = scl_d && scl_in && sda_d && !sda_in;
	// Raw pin edges; a start forgets the last written address
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			seen <= 1'b0;
			last <= 8'h00;
		end
		else
		begin
			scl_d <= scl_in;
			sda_d <= sda_in;
			seen <= sta ? 1'b0 : (seen | wr_valid);
			last <= wr_valid ? wr.addr : last;
		end
	end
	a_oe_busy: assert property (sda_oe |-> busy) else $error("drive while idle");
	a_oe_low: assert property (sda_oe |-> !sda_out) else $error("drives high");
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("moved when high");
	a_ack_span: assert property ($rose(sda_oe) |-> sda_oe[*4]) else $error("short drive");
	a_wr_in_ack: assert property (wr_valid |-> $rose(sda_oe)) else $error("write off ack");
	a_wr_pulse: assert property (wr_valid |=> !wr_valid) else $error("long write");
	a_ptr_step: assert property (wr_valid && seen |-> wr.addr == last + 8'h01)
		else $error("pointer step");
	a_rd_pulse: assert property (rd_req |=> !rd_req) else $error("long read");
	a_stop_idle: assert property (stp |-> ##[1:8] !busy) else $error("busy after stop");
	cover property (wr_valid);
	cover property (rd_req);
	cover property ($rose(sda_oe) ##[1:20] !sda_oe);
endmodule

bind ldi_target ldi_target_chk u_chk(.clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .strap_in_low(strap_in_low),
	.strap_in_high(strap_in_high), .wr(wr), .wr_valid(wr_valid), .rd_req(rd_req),
	.rd_addr(rd_addr), .rd_data(rd_data), .busy(busy));

// [bench/ldi_ctrl_model.sv]
// Bus controller model: 800 ns clock, 500 low and 300 high.
// Assumes a pull-up on the data wire, read back on sda.
`timescale 1ns/1ps
module ldi_ctrl_model
(
	output logic scl,
	output logic pull,
	input wire logic sda
);
	// Extra low time, to play a slow controller
	int slow = 0;
	initial
	begin
		scl = 1'b1;
		pull = 1'b0;
	end
	task automatic bit_io(input logic b, output logic r);
		pull = !b;
		#300;
		scl = 1'b1;
		#150;
		r = sda;
		#150;
		scl = 1'b0;
		#(200 + slow);
	endtask
	task automatic start;
		pull = 1'b0;
		#300;
		scl = 1'b1;
		#300;
		pull = 1'b1;
		#300;
		scl = 1'b0;
		#200;
	endtask
	task automatic stop;
		pull = 1'b1;
		#300;
		scl = 1'b1;
		#300;
		pull = 1'b0;
		#600;
	endtask
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
		output logic r);
		logic t;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(d[i], t);
			q[i] = t;
		end
		bit_io(a, r);
	endtask
endmodule

// [bench/test_led_driver_i2c_target_port.sv]
// Self-checking bench of the serial target port, all strap cases.
// Assumes the controller model and a small register bank here.
`timescale 1ns/1ps
module test_led_driver_i2c_target_port;
	import ldi_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, sda, oe, so, wv, rq, busy, scl, pull, r;
	logic sl_pin, sh_pin;
	logic [1:0] sl, sh;
	logic [7:0] ra, rdd, q;
	logic [7:0] bank [256];
	logic [7:0] em [256];
	ldi_wr_t w;
	int failures = 0, num_checks = 0;
	integer seed = 58685;
	always #50 clk = !clk;
	// Open drain wire with pull-up; straps 00 gnd, 01 clock, 10 data, 11 supply
	assign sda = !(pull | (oe & !so));
	assign sl_pin = sl[1] ? (sl[0] | sda) : (sl[0] & scl);
	assign sh_pin = sh[1] ? (sh[0] | sda) : (sh[0] & scl);
	assign rdd = bank[ra];
	always @(posedge clk)
		if (wv)
			bank[w.addr] <= w.data;
	ldi_target uut(.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(so),
		.sda_oe(oe), .strap_in_low(sl_pin), .strap_in_high(sh_pin), .wr(w), .wr_valid(wv),
		.rd_req(rq), .rd_addr(ra), .rd_data(rdd), .busy(busy));
	ldi_ctrl_model m(.scl(scl), .pull(pull), .sda(sda));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Send one byte, compare the acknowledge level
	task automatic wb(input logic [7:0] d, input logic e);
		m.xfer(d, 1'b1, q, r);
		chk({7'h00, r}, {7'h00, e});
	endtask
	initial
	begin
		#5000000;
		$display("unexpected at %0t: watchdog expired", $time);
		failures++;
		end_of_test;
	end
	initial
	begin
		logic [6:0] id;
		int p;
		{sh, sl} = 4'h0;
		for (int k = 0; k < 16; k++)
		begin
			// One device alone on the bus, so every strap case is usable
			{sh, sl} = k[3:0];
			m.slow = (k == 5) ? 2000 : 0;
			rst_n = 1'b0;
			repeat (5) @(negedge clk);
			rst_n = 1'b1;
			repeat (3) @(negedge clk);
			id = {3'h4, sh, sl};
			p = $unsigned($random(seed)) % 250;
			m.start;
			wb({id ^ (7'h01 << (k % 7)), 1'b0}, 1'b1);
			m.stop;
			chk({7'h00, busy}, 8'h00);
			m.start;
			wb({id, 1'b0}, 1'b0);
			wb(p[7:0], 1'b0);
			for (int i = 0; i < 3; i++)
			begin
				em[p + i] = 8'($random(seed));
				wb(em[p + i], 1'b0);
			end
			m.stop;
			for (int i = 0; i < 3; i++)
				chk(bank[p + i], em[p + i]);
			m.start;
			wb({id, 1'b0}, 1'b0);
			wb(p[7:0], 1'b0);
			m.start;
			wb({id, 1'b1}, 1'b0);
			m.xfer(8'hff, 1'b0, q, r);
			chk(q, em[p]);
			m.xfer(8'hff, 1'b1, q, r);
			chk(q, em[p + 1]);
			chk({7'h00, sda}, 8'h01);
			m.stop;
			chk({7'h00, sda}, 8'h01);
			$display("strap case %0d done", k);
		end
		end_of_test;
	end
endmodule
